// file: pkg/bus_matrix_pkg.sv
// constants for the core bus matrix router: region bounds, attributes, timing
// assumes a 32-bit address space and word-only access in the private ranges
package bus_matrix_pkg;
	localparam logic [31:0] IO_BASE      = 32'hd000_0000;
	localparam logic [31:0] IO_LAST      = 32'hdfff_ffff;
	localparam logic [31:0] PRIV_BASE    = 32'he000_0000;
	localparam logic [31:0] PRIV_LAST    = 32'hefff_ffff;
	localparam logic [31:0] CODE_LO_LAST = 32'h3fff_ffff;
	localparam logic [31:0] CODE_HI_BASE = 32'h6000_0000;
	localparam logic [31:0] CODE_HI_LAST = 32'h9fff_ffff;
	localparam logic [31:0] DEV_LO_BASE  = 32'h4000_0000;
	localparam logic [31:0] DEV_LO_LAST  = 32'h5fff_ffff;
	localparam logic [31:0] DEV_HI_BASE  = 32'ha000_0000;
	localparam logic [31:0] DEV_TOP_BASE = 32'hf000_0000;
	localparam logic [2:0]  SIZE_WORD    = 3'h2;
	localparam logic [1:0]  HTRANS_IDLE  = 2'h0;
	localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
	localparam int          EXT_CYCLES   = 2;
	localparam int          IO_CYCLES    = 1;
	typedef enum logic [1:0] {TGT_EXT, TGT_IO, TGT_PRIV} target_t;
	typedef enum {ST_IDLE, ST_DATA} phase_t;
endpackage

// file: core/region_decode.sv
// shared address decoder: target and default region attributes
// purely combinational; used identically for both requesters
`timescale 1ns/1ps
module region_decode (
	// address in
	input  wire logic                     [31:0] addr_i,
	// decode out
	output bus_matrix_pkg::target_t              target_o,
	output logic                                 code_ok_o,
	output logic                                 device_o,
	output logic                                 word_only_o
);
	always_comb begin
		if (addr_i >= bus_matrix_pkg::PRIV_BASE && addr_i <= bus_matrix_pkg::PRIV_LAST) begin
			target_o = bus_matrix_pkg::TGT_PRIV;
		end else if (addr_i >= bus_matrix_pkg::IO_BASE && addr_i <= bus_matrix_pkg::IO_LAST) begin
			target_o = bus_matrix_pkg::TGT_IO;
		end else begin
			target_o = bus_matrix_pkg::TGT_EXT;
		end
		code_ok_o = (addr_i <= bus_matrix_pkg::CODE_LO_LAST) ||
			(addr_i >= bus_matrix_pkg::CODE_HI_BASE && addr_i <= bus_matrix_pkg::CODE_HI_LAST);
		device_o = (addr_i >= bus_matrix_pkg::DEV_LO_BASE && addr_i <= bus_matrix_pkg::DEV_LO_LAST) ||
			(addr_i >= bus_matrix_pkg::DEV_HI_BASE && addr_i <= bus_matrix_pkg::IO_LAST) ||
			(addr_i >= bus_matrix_pkg::DEV_TOP_BASE);
		word_only_o = (addr_i >= bus_matrix_pkg::IO_BASE && addr_i <= bus_matrix_pkg::PRIV_LAST);
	end
endmodule // region_decode

// file: core/core_bus_matrix_router.sv
// core bus matrix router: arbitrates core and debug access port, routes by address
// assumes zero-wait targets answer as described in the handover; one clock domain
//
// What this block does
// - Core and debug requests are arbitrated and the core always wins a tie.
// - Debug traffic only starts in cycles without a core request; a core request arriving while one is in flight waits.
// - Both requesters share one address decoder, so an address always hits one target.
// - Addresses below the I/O range or above the private range go to the AHB-Lite port.
// - Addresses in the I/O range go to the single-cycle I/O block.
// - Addresses in the private range are served internally and never reach AHB-Lite.
// - In the I/O and private ranges only word accesses are made; others are refused.
// - Default attributes mark code, data and device regions per the fixed map.
// - A fetch from a region that is not code-capable is blocked and raises a hard fault.
// - A protection unit may override the code-capable attribute except in the private range.
// - A single access takes three cycles plus wait states to AHB-Lite, two to private space and one to I/O.
`timescale 1ns/1ps
module core_bus_matrix_router (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        clk_en_i,
	// core request
	input  wire logic        core_req_i,
	input  wire logic        core_fetch_i,
	input  wire logic        core_write_i,
	input  wire logic [2:0]  core_size_i,
	input  wire logic [31:0] core_addr_i,
	input  wire logic [31:0] core_wdata_i,
	output logic             core_done_o,
	output logic [31:0]      core_rdata_o,
	output logic             core_err_o,
	output logic             hard_fault_exception_o,
	// debug access port request
	input  wire logic        debug_access_port_req_i,
	input  wire logic        debug_access_port_write_i,
	input  wire logic [2:0]  debug_access_port_size_i,
	input  wire logic [31:0] debug_access_port_addr_i,
	input  wire logic [31:0] debug_access_port_wdata_i,
	output logic             debug_access_port_done_o,
	output logic [31:0]      debug_access_port_rdata_o,
	output logic             debug_access_port_err_o,
	// protection unit override, ignored in private space
	input  wire logic        memory_protection_unit_en_i,
	input  wire logic        memory_protection_unit_code_ok_i,
	// ahb-lite master
	output logic [31:0]      haddr_o,
	output logic [1:0]       htrans_o,
	output logic             hwrite_o,
	output logic [2:0]       hsize_o,
	output logic [31:0]      hwdata_o,
	input  wire logic [31:0] hrdata_i,
	input  wire logic        hready_i,
	input  wire logic        hresp_i,
	// single-cycle i/o block
	output logic             single_cycle_io_block_sel_o,
	output logic             single_cycle_io_block_write_o,
	output logic [31:0]      single_cycle_io_block_addr_o,
	output logic [31:0]      single_cycle_io_block_wdata_o,
	input  wire logic [31:0] single_cycle_io_block_rdata_i,
	// internal irq controller and debug space
	output logic             system_control_space_sel_o,
	output logic             system_control_space_write_o,
	output logic [31:0]      system_control_space_addr_o,
	output logic [31:0]      system_control_space_wdata_o,
	input  wire logic [31:0] system_control_space_rdata_i
);
	// pending debug request, phase and master of the request in data phase
	logic                    dbg_pend_q, dbg_pend_d;
	logic                    dbg_wr_q, dbg_wr_d;
	logic [2:0]              dbg_size_q, dbg_size_d;
	logic [31:0]             dbg_addr_q, dbg_addr_d;
	logic [31:0]             dbg_wdata_q, dbg_wdata_d;
	bus_matrix_pkg::phase_t  phase_q, phase_d;
	logic                    own_dbg_q, own_dbg_d;
	bus_matrix_pkg::target_t tgt_q, tgt_d;
	logic [31:0]             wdata_q, wdata_d;
	// registered outputs
	logic                    core_done_d, core_err_d, fault_d;
	logic [31:0]             core_rdata_d;
	logic                    dbg_done_d, dbg_err_d;
	logic [31:0]             dbg_rdata_d;
	logic [31:0]             haddr_d;
	logic [1:0]              htrans_d;
	logic                    hwrite_d;
	logic [2:0]              hsize_d;
	logic                    io_sel_d, io_wr_d, scs_sel_d, scs_wr_d;
	logic [31:0]             io_addr_d, scs_addr_d, side_wdata_d;

	// arbitrated request
	logic                    sel_dbg, sel_valid, sel_fetch, sel_wr, code_ok;
	logic [2:0]              sel_size;
	logic [31:0]             sel_addr, sel_wdata;
	bus_matrix_pkg::target_t sel_tgt;
	logic                    sel_code_ok, sel_device, sel_word_only;
	logic                    accept;

	region_decode u_decode (
		.addr_i      (sel_addr),
		.target_o    (sel_tgt),
		.code_ok_o   (sel_code_ok),
		.device_o    (sel_device),
		.word_only_o (sel_word_only)
	);

	always_comb begin
		// one access in flight: a core request held until done must not be taken twice
		accept = (phase_q == bus_matrix_pkg::ST_IDLE) &&
			(htrans_o == bus_matrix_pkg::HTRANS_IDLE) && !system_control_space_sel_o;
		sel_dbg   = !core_req_i && dbg_pend_q;
		sel_valid = core_req_i || dbg_pend_q;
		sel_fetch = core_req_i && core_fetch_i;
		sel_wr    = sel_dbg ? dbg_wr_q : core_write_i;
		sel_size  = sel_dbg ? dbg_size_q : core_size_i;
		sel_addr  = sel_dbg ? dbg_addr_q : core_addr_i;
		sel_wdata = sel_dbg ? dbg_wdata_q : core_wdata_i;
		code_ok = (memory_protection_unit_en_i && sel_tgt != bus_matrix_pkg::TGT_PRIV) ?
			memory_protection_unit_code_ok_i : sel_code_ok;
	end

	always_comb begin
		dbg_pend_d  = dbg_pend_q;
		dbg_wr_d    = dbg_wr_q;
		dbg_size_d  = dbg_size_q;
		dbg_addr_d  = dbg_addr_q;
		dbg_wdata_d = dbg_wdata_q;
		phase_d     = phase_q;
		own_dbg_d   = own_dbg_q;
		tgt_d       = tgt_q;
		wdata_d     = wdata_q;
		core_done_d = 1'b0;
		core_err_d  = 1'b0;
		fault_d     = 1'b0;
		core_rdata_d = core_rdata_o;
		dbg_done_d  = 1'b0;
		dbg_err_d   = 1'b0;
		dbg_rdata_d = debug_access_port_rdata_o;
		haddr_d     = haddr_o;
		htrans_d    = bus_matrix_pkg::HTRANS_IDLE;
		hwrite_d    = hwrite_o;
		hsize_d     = hsize_o;
		io_sel_d    = 1'b0;
		io_wr_d     = 1'b0;
		scs_sel_d   = 1'b0;
		scs_wr_d    = 1'b0;
		io_addr_d   = single_cycle_io_block_addr_o;
		scs_addr_d  = system_control_space_addr_o;
		side_wdata_d = single_cycle_io_block_wdata_o;

		// capture and hold a new debug request whenever none is pending
		if (!dbg_pend_q && debug_access_port_req_i) begin
			dbg_pend_d  = 1'b1;
			dbg_wr_d    = debug_access_port_write_i;
			dbg_size_d  = debug_access_port_size_i;
			dbg_addr_d  = debug_access_port_addr_i;
			dbg_wdata_d = debug_access_port_wdata_i;
		end

		// finish external data phase
		if (phase_q == bus_matrix_pkg::ST_DATA && hready_i) begin
			phase_d = bus_matrix_pkg::ST_IDLE;
			if (own_dbg_q) begin
				dbg_done_d  = 1'b1;
				dbg_err_d   = hresp_i;
				dbg_rdata_d = hrdata_i;
			end else begin
				core_done_d  = 1'b1;
				core_err_d   = hresp_i;
				core_rdata_d = hrdata_i;
			end
		end
		// data phase opens once the slave takes our address phase
		if (htrans_o == bus_matrix_pkg::HTRANS_NSEQ) begin
			if (hready_i) begin
				phase_d = bus_matrix_pkg::ST_DATA;
			end else begin
				htrans_d = bus_matrix_pkg::HTRANS_NSEQ;
			end
		end
		// finish private-space access one cycle after select
		if (system_control_space_sel_o) begin
			if (own_dbg_q) begin
				dbg_done_d  = 1'b1;
				dbg_rdata_d = system_control_space_rdata_i;
			end else begin
				core_done_d  = 1'b1;
				core_rdata_d = system_control_space_rdata_i;
			end
		end

		// debug uses only cycles the core leaves free
		if (sel_valid && accept) begin
			if (sel_dbg) begin
				dbg_pend_d = 1'b0;
			end
			own_dbg_d = sel_dbg;
			tgt_d     = sel_tgt;
			wdata_d   = sel_wdata;
			if (sel_fetch && !code_ok) begin
				core_done_d = 1'b1;
				core_err_d  = 1'b1;
				fault_d     = 1'b1;
			end else if (sel_word_only && sel_size != bus_matrix_pkg::SIZE_WORD) begin
				if (sel_dbg) begin
					dbg_done_d = 1'b1;
					dbg_err_d  = 1'b1;
				end else begin
					core_done_d = 1'b1;
					core_err_d  = 1'b1;
				end
			end else begin
				case (sel_tgt)
					bus_matrix_pkg::TGT_IO: begin
						io_sel_d     = 1'b1;
						io_wr_d      = sel_wr;
						io_addr_d    = sel_addr;
						side_wdata_d = sel_wdata;
						if (sel_dbg) begin
							dbg_done_d  = 1'b1;
							dbg_rdata_d = single_cycle_io_block_rdata_i;
						end else begin
							core_done_d  = 1'b1;
							core_rdata_d = single_cycle_io_block_rdata_i;
						end
					end
					bus_matrix_pkg::TGT_PRIV: begin
						scs_sel_d    = 1'b1;
						scs_wr_d     = sel_wr;
						scs_addr_d   = sel_addr;
						side_wdata_d = sel_wdata;
					end
					default: begin
						htrans_d = bus_matrix_pkg::HTRANS_NSEQ;
						haddr_d  = sel_addr;
						hwrite_d = sel_wr;
						hsize_d  = sel_size;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dbg_pend_q  <= 1'b0;
			dbg_wr_q    <= 1'b0;
			dbg_size_q  <= 3'h0;
			dbg_addr_q  <= 32'h0000_0000;
			dbg_wdata_q <= 32'h0000_0000;
			phase_q     <= bus_matrix_pkg::ST_IDLE;
			own_dbg_q   <= 1'b0;
			tgt_q       <= bus_matrix_pkg::TGT_EXT;
			wdata_q     <= 32'h0000_0000;
			core_done_o <= 1'b0;
			core_err_o  <= 1'b0;
			hard_fault_exception_o <= 1'b0;
			core_rdata_o <= 32'h0000_0000;
			debug_access_port_done_o  <= 1'b0;
			debug_access_port_err_o   <= 1'b0;
			debug_access_port_rdata_o <= 32'h0000_0000;
			haddr_o     <= 32'h0000_0000;
			htrans_o    <= bus_matrix_pkg::HTRANS_IDLE;
			hwrite_o    <= 1'b0;
			hsize_o     <= 3'h0;
			hwdata_o    <= 32'h0000_0000;
			single_cycle_io_block_sel_o   <= 1'b0;
			single_cycle_io_block_write_o <= 1'b0;
			single_cycle_io_block_addr_o  <= 32'h0000_0000;
			single_cycle_io_block_wdata_o <= 32'h0000_0000;
			system_control_space_sel_o    <= 1'b0;
			system_control_space_write_o  <= 1'b0;
			system_control_space_addr_o   <= 32'h0000_0000;
			system_control_space_wdata_o  <= 32'h0000_0000;
		end else if (clk_en_i) begin
			dbg_pend_q  <= dbg_pend_d;
			dbg_wr_q    <= dbg_wr_d;
			dbg_size_q  <= dbg_size_d;
			dbg_addr_q  <= dbg_addr_d;
			dbg_wdata_q <= dbg_wdata_d;
			phase_q     <= phase_d;
			own_dbg_q   <= own_dbg_d;
			tgt_q       <= tgt_d;
			wdata_q     <= wdata_d;
			core_done_o <= core_done_d;
			core_err_o  <= core_err_d;
			hard_fault_exception_o <= fault_d;
			core_rdata_o <= core_rdata_d;
			debug_access_port_done_o  <= dbg_done_d;
			debug_access_port_err_o   <= dbg_err_d;
			debug_access_port_rdata_o <= dbg_rdata_d;
			haddr_o     <= haddr_d;
			htrans_o    <= htrans_d;
			hwrite_o    <= hwrite_d;
			hsize_o     <= hsize_d;
			// write data follows the address phase by one cycle
			if (htrans_o == bus_matrix_pkg::HTRANS_NSEQ && hready_i) begin
				hwdata_o <= wdata_q;
			end
			single_cycle_io_block_sel_o   <= io_sel_d;
			single_cycle_io_block_write_o <= io_wr_d;
			single_cycle_io_block_addr_o  <= io_addr_d;
			single_cycle_io_block_wdata_o <= side_wdata_d;
			system_control_space_sel_o    <= scs_sel_d;
			system_control_space_write_o  <= scs_wr_d;
			system_control_space_addr_o   <= scs_addr_d;
			system_control_space_wdata_o  <= side_wdata_d;
		end
	end
endmodule // core_bus_matrix_router

// file: tb/core_bus_matrix_router_properties.sv
// port-level checks of the core bus matrix router
// assumes bus_matrix_pkg is compiled first; bound below
`timescale 1ns/1ps
module core_bus_matrix_router_properties (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        clk_en_i,
	// requester side
	input wire logic        core_req_i,
	input wire logic        core_done_o,
	input wire logic        core_err_o,
	input wire logic        hard_fault_exception_o,
	input wire logic        debug_access_port_done_o,
	// target side
	input wire logic [31:0] haddr_o,
	input wire logic [1:0]  htrans_o,
	input wire logic        hready_i,
	input wire logic        single_cycle_io_block_sel_o,
	input wire logic [31:0] single_cycle_io_block_addr_o,
	input wire logic        system_control_space_sel_o,
	input wire logic [31:0] system_control_space_addr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic any_done;
	logic nseq;
	assign any_done = core_done_o || debug_access_port_done_o;
	assign nseq = htrans_o == bus_matrix_pkg::HTRANS_NSEQ;
	sequence ahb_addr_phase;
		clk_en_i && nseq && hready_i;
	endsequence
	sequence ahb_data_end;
		clk_en_i && hready_i;
	endsequence
	AST_AHB_OUTSIDE: assert property (nseq |-> (haddr_o < bus_matrix_pkg::IO_BASE ||
		haddr_o > bus_matrix_pkg::PRIV_LAST)) else $error("ahb transfer in private range");
	AST_IO_RANGE: assert property (single_cycle_io_block_sel_o |->
		single_cycle_io_block_addr_o[31:28] == 4'hd) else $error("i/o select out of range");
	AST_SCS_RANGE: assert property (system_control_space_sel_o |->
		system_control_space_addr_o[31:28] == 4'he) else $error("private select out of range");
	AST_ONE_TARGET: assert property ($onehot0({single_cycle_io_block_sel_o,
		system_control_space_sel_o, nseq})) else $error("two targets at once");
	AST_IO_SINGLE: assert property (single_cycle_io_block_sel_o |-> any_done)
		else $error("i/o access not single cycle");
	AST_SCS_TWO: assert property (system_control_space_sel_o && clk_en_i |=> any_done)
		else $error("private access not two cycles");
	AST_AHB_DONE: assert property (ahb_addr_phase ##1 ahb_data_end |=> any_done)
		else $error("ahb access not finished after data phase");
	AST_FAULT_ERR: assert property (hard_fault_exception_o |-> core_done_o && core_err_o)
		else $error("fault without core error");
	AST_CORE_BOUND: assert property ($rose(core_req_i) |-> ##[1:16] core_done_o)
		else $error("core request starved");
endmodule // core_bus_matrix_router_properties
bind core_bus_matrix_router core_bus_matrix_router_properties u_props (.*);

// file: tb/bus_far_side_model.sv
// far side: ahb-lite slave with wait states, i/o block, private space
// assumes the bench supplies the i/o request address combinationally
`timescale 1ns/1ps
module bus_far_side_model #(
	parameter logic [31:0] AHB_PAT = 32'h1234_0000,
	parameter logic [31:0] IO_PAT  = 32'h00a5_5a00,
	parameter logic [31:0] SCS_PAT = 32'h0f00_00f0
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// ahb-lite slave
	input  wire logic [1:0]  wait_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	output logic [31:0]      hrdata_o,
	output logic             hready_o,
	output logic             hresp_o,
	// i/o block and private space
	input  wire logic [31:0] io_addr_i,
	output logic [31:0]      io_rdata_o,
	input  wire logic        scs_sel_i,
	input  wire logic [31:0] scs_addr_i,
	output logic [31:0]      scs_rdata_o
);
	logic        dphase_q, dphase_d;
	logic [31:0] addr_q, addr_d;
	logic [1:0]  cnt_q, cnt_d;
	assign hresp_o = 1'b0;
	assign hready_o = !dphase_q || cnt_q == wait_i;
	// off data phase the bus shows the inverse, never a stale match
	assign hrdata_o = (dphase_q && hready_o) ? addr_q ^ AHB_PAT : ~(addr_q ^ AHB_PAT);
	assign io_rdata_o = io_addr_i ^ IO_PAT;
	assign scs_rdata_o = scs_sel_i ? scs_addr_i ^ SCS_PAT : ~(scs_addr_i ^ SCS_PAT);
	always_comb begin
		dphase_d = dphase_q;
		addr_d = addr_q;
		cnt_d = cnt_q + 2'h1;
		if (hready_o) begin
			dphase_d = htrans_i == bus_matrix_pkg::HTRANS_NSEQ;
			addr_d = haddr_i;
			cnt_d = 2'h0;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dphase_q <= 1'b0;
			addr_q <= 32'h0;
			cnt_q <= 2'h0;
		end else begin
			dphase_q <= dphase_d;
			addr_q <= addr_d;
			cnt_q <= cnt_d;
		end
	end
endmodule // bus_far_side_model

// file: tb/core_bus_matrix_router_tb_top.sv
// self-checking bench for the core bus matrix router
// assumes the far-side model answers every target with zero or more waits
`timescale 1ns/1ps
module core_bus_matrix_router_tb_top;
	localparam logic [31:0] AHB_PAT = 32'h1234_0000;
	localparam logic [31:0] IO_PAT = 32'h00a5_5a00;
	localparam logic [31:0] SCS_PAT = 32'h0f00_00f0;
	logic clk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1;
	logic core_req_i = 1'b0, core_fetch_i = 1'b0, core_write_i = 1'b0;
	logic [2:0] core_size_i = 3'h2, debug_access_port_size_i = 3'h2;
	logic [31:0] core_addr_i = 32'h0, core_wdata_i = 32'h0;
	logic debug_access_port_req_i = 1'b0, debug_access_port_write_i = 1'b0;
	logic [31:0] debug_access_port_addr_i = 32'h0, debug_access_port_wdata_i = 32'h0;
	logic memory_protection_unit_en_i = 1'b0, memory_protection_unit_code_ok_i = 1'b0;
	logic [1:0] wait_n = 2'h0;
	logic core_done_o, core_err_o, hard_fault_exception_o, debug_access_port_done_o;
	logic debug_access_port_err_o, hwrite_o, hready_i, hresp_i, system_control_space_sel_o;
	logic single_cycle_io_block_sel_o, single_cycle_io_block_write_o, system_control_space_write_o;
	logic [1:0] htrans_o;
	logic [2:0] hsize_o;
	logic [31:0] core_rdata_o, debug_access_port_rdata_o, haddr_o, hwdata_o, hrdata_i;
	logic [31:0] single_cycle_io_block_addr_o, single_cycle_io_block_wdata_o;
	logic [31:0] single_cycle_io_block_rdata_i, system_control_space_addr_o;
	logic [31:0] system_control_space_wdata_o, system_control_space_rdata_i;
	int n_errors = 0, comparisons = 0, cyc = 0;
	core_bus_matrix_router DUT (.*);
	bus_far_side_model #(.AHB_PAT(AHB_PAT), .IO_PAT(IO_PAT), .SCS_PAT(SCS_PAT)) far (.clk_i,
		.reset_n_i, .wait_i(wait_n), .haddr_i(haddr_o), .htrans_i(htrans_o), .hrdata_o(hrdata_i),
		.hready_o(hready_i), .hresp_o(hresp_i), .scs_sel_i(system_control_space_sel_o),
		.io_addr_i(core_req_i ? core_addr_i : debug_access_port_addr_i),
		.io_rdata_o(single_cycle_io_block_rdata_i), .scs_addr_i(system_control_space_addr_o),
		.scs_rdata_o(system_control_space_rdata_i));
	function automatic logic in_io(input logic [31:0] a);
		return a >= bus_matrix_pkg::IO_BASE && a <= bus_matrix_pkg::IO_LAST;
	endfunction
	function automatic logic in_priv(input logic [31:0] a);
		return a >= bus_matrix_pkg::PRIV_BASE && a <= bus_matrix_pkg::PRIV_LAST;
	endfunction
	function automatic logic code(input logic [31:0] a);
		return a <= bus_matrix_pkg::CODE_LO_LAST ||
			(a >= bus_matrix_pkg::CODE_HI_BASE && a <= bus_matrix_pkg::CODE_HI_LAST);
	endfunction
	function automatic logic [31:0] pat(input logic [31:0] a);
		return a ^ (in_io(a) ? IO_PAT : in_priv(a) ? SCS_PAT : AHB_PAT);
	endfunction
	// ahb address phase rides one cycle ahead of the data phase
	function automatic int cyc_of(input logic [31:0] a);
		return in_io(a) ? bus_matrix_pkg::IO_CYCLES : in_priv(a) ? bus_matrix_pkg::EXT_CYCLES
			: bus_matrix_pkg::EXT_CYCLES + 1 + int'(wait_n);
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic core_acc(input logic [31:0] a, input logic [2:0] sz, input logic f,
		input logic w, input int exp_n, input logic er);
		int n;
		int hits;
		logic [31:0] wd;
		n = 0;
		hits = 0;
		@(negedge clk_i);
		core_addr_i = a;
		core_wdata_i = ~a;
		core_size_i = sz;
		core_fetch_i = f;
		core_write_i = w;
		core_req_i = 1'b1;
		do begin
			@(negedge clk_i);
			n++;
			if (single_cycle_io_block_sel_o === 1'b1) begin
				hits++;
				check("io target", in_io(a), 1'b1);
				check("io addr", single_cycle_io_block_addr_o, a);
				check("io write", single_cycle_io_block_write_o, w);
			end
			if (system_control_space_sel_o === 1'b1) begin
				hits++;
				check("private target", in_priv(a), 1'b1);
				check("private addr", system_control_space_addr_o, a);
				check("private write", system_control_space_write_o, w);
			end
			if (htrans_o === bus_matrix_pkg::HTRANS_NSEQ) begin
				hits++;
				check("ahb target", !in_io(a) && !in_priv(a), 1'b1);
				check("haddr", haddr_o, a);
				check("hwrite", hwrite_o, w);
				check("hsize", hsize_o, sz);
			end
		end while (core_done_o !== 1'b1 && n < 40);
		core_req_i = 1'b0;
		wd = in_io(a) ? single_cycle_io_block_wdata_o :
			in_priv(a) ? system_control_space_wdata_o : hwdata_o;
		check("targets hit", hits, !er);
		if (!er && w) check("wdata", wd, ~a);
		check("cycles", n, exp_n);
		check("error", core_err_o, er);
		check("fault", hard_fault_exception_o, er & f);
		if (!er && !w) check("rdata", core_rdata_o, pat(a));
	endtask
	task automatic s_route;
		logic [31:0] a [8];
		a = '{32'h2000_0000, 32'h4000_0004, 32'hcfff_fffc, 32'hf000_0000,
			32'hd000_0000, 32'hdfff_fffc, 32'he000_0000, 32'hefff_fffc};
		for (int i = 0; i < 16; i++) begin
			wait_n = 2'(i % 3);
			core_acc(a[i % 8], bus_matrix_pkg::SIZE_WORD, 1'b0, i >= 8, cyc_of(a[i % 8]), 1'b0);
		end
		core_acc(32'hd000_0010, 3'h0, 1'b0, 1'b0, 1, 1'b1);
		core_acc(32'he000_0100, 3'h1, 1'b0, 1'b1, 1, 1'b1);
		// sub-word outside the private ranges is allowed
		core_acc(32'h2000_0002, 3'h1, 1'b0, 1'b0, cyc_of(32'h2000_0002), 1'b0);
	endtask
	task automatic s_freeze;
		@(negedge clk_i);
		clk_en_i = 1'b0;
		core_addr_i = 32'hd000_0004;
		core_size_i = bus_matrix_pkg::SIZE_WORD;
		core_fetch_i = 1'b0;
		core_write_i = 1'b0;
		core_req_i = 1'b1;
		repeat (3) @(negedge clk_i);
		check("frozen", core_done_o, 1'b0);
		clk_en_i = 1'b1;
		@(negedge clk_i);
		core_req_i = 1'b0;
		check("thawed", core_done_o, 1'b1);
		check("thawed rdata", core_rdata_o, pat(32'hd000_0004));
	endtask
	task automatic s_fetch;
		logic [31:0] a [9];
		logic xn;
		a = '{32'h0000_0000, 32'h3fff_fffc, 32'h6000_0000, 32'h9fff_fffc, 32'h4000_0000,
			32'ha000_0000, 32'hd000_0000, 32'he000_0000, 32'hf000_0000};
		for (int m = 0; m < 3; m++) begin
			memory_protection_unit_en_i = m > 0;
			memory_protection_unit_code_ok_i = m == 2;
			for (int i = 0; i < 9; i++) begin
				xn = in_priv(a[i]) || (m == 0 ? !code(a[i]) : m == 1);
				core_acc(a[i], bus_matrix_pkg::SIZE_WORD, 1'b1, 1'b0, xn ? 1 : cyc_of(a[i]), xn);
			end
		end
	endtask
	task automatic s_debug(input logic [31:0] ca, input logic [31:0] da);
		int n;
		n = 0;
		@(negedge clk_i);
		core_addr_i = ca;
		core_fetch_i = 1'b0;
		core_write_i = 1'b0;
		core_size_i = bus_matrix_pkg::SIZE_WORD;
		debug_access_port_addr_i = da;
		debug_access_port_size_i = bus_matrix_pkg::SIZE_WORD;
		core_req_i = 1'b1;
		debug_access_port_req_i = 1'b1;
		do begin
			@(negedge clk_i);
			n++;
			debug_access_port_req_i = 1'b0;
			// held request must ignore later input changes
			debug_access_port_size_i = 3'h0;
			if (core_done_o === 1'b1) begin
				check("core first", n, cyc_of(ca));
				core_req_i = 1'b0;
			end
		end while (debug_access_port_done_o !== 1'b1 && n < 40);
		check("debug after core", n > cyc_of(ca), 1'b1);
		check("debug rdata", debug_access_port_rdata_o, pat(da));
		check("debug err", debug_access_port_err_o, 1'b0);
	endtask
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// ceiling well above the fewer than two hundred cycles the tests need
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		reset_n_i = 1'b1;
		s_route();
		s_freeze();
		s_fetch();
		memory_protection_unit_en_i = 1'b0;
		s_debug(32'hd000_0040, 32'hd000_0080);
		s_debug(32'h2000_0100, 32'he000_0010);
		s_debug(32'he000_0020, 32'h4000_0000);
		finish_test();
	end
endmodule // core_bus_matrix_router_tb_top
